// [bench/fifo_flag_sync_and_depth_chain_sva.sv]
`timescale 1ns/1ps
module fifo_flag_sync_and_depth_chain_sva (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic a_select_n,
    input wire logic a_direction,
    input wire logic a_mail_select,
    input wire logic a_enable,
    input wire logic input_ready_flag,
    input wire logic high_level_flag_n,
    input wire logic b_select_n,
    input wire logic b_direction,
    input wire logic b_mail_select,
    input wire logic b_enable,
    input wire logic replay_mode_select,
    input wire logic output_ready,
    input wire logic low_level_flag_n
);
    logic wt;
    logic rt;
    assign wt = !a_select_n && a_direction && !a_mail_select && a_enable && input_ready_flag;
    assign rt = !b_select_n && b_direction && !b_mail_select && b_enable && output_ready;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Older transfers still in the sync stages would move the flags early, so they are excluded.
    sequence s_or_up;
        !output_ready [*3] ##1 output_ready;
    endsequence
    sequence s_in_ready_up;
        !input_ready_flag [*2] ##1 input_ready_flag;
    endsequence
    property p_fall_through;
        !output_ready && wt && !replay_mode_select && !$past(wt) && !$past(wt, 2)
            && !$past(wt, 3) |-> ##1 s_or_up;
    endproperty
    property p_in_ready_rise;
        !input_ready_flag && rt && !replay_mode_select && !$past(rt) && !$past(rt, 2)
            |-> ##1 s_in_ready_up;
    endproperty
    property p_high_level_rise;
        $rose(high_level_flag_n) |-> $past(rt, 3) || $past(replay_mode_select, 4);
    endproperty
    // A write reaches the low-level flag through two delay stages and its register,
    // so the flag is first seen high four edges after the write.
    property p_low_level_rise;
        $rose(low_level_flag_n) && !$past(replay_mode_select) |-> $past(wt, 4);
    endproperty
    property p_in_ready_fall;
        $fell(input_ready_flag) |-> $past(wt);
    endproperty
    property p_or_fall;
        $fell(output_ready) |-> $past(rt);
    endproperty
    property p_no_mail;
        !a_mail_select && !b_mail_select;
    endproperty
    property p_sel;
        a_enable || b_enable |-> !a_select_n && a_direction && !b_select_n && b_direction;
    endproperty
    a_fall_through: assert property (p_fall_through)
        else $error("output ready timing wrong after write");
    a_in_ready_rise: assert property (p_in_ready_rise)
        else $error("input ready timing wrong after read");
    a_high_level_rise: assert property (p_high_level_rise)
        else $error("high level flag rose without read");
    a_low_level_rise: assert property (p_low_level_rise)
        else $error("low level flag rose without write");
    a_in_ready_fall: assert property (p_in_ready_fall)
        else $error("input ready fell without write");
    a_or_fall: assert property (p_or_fall)
        else $error("output ready fell without read");
    a_no_mail: assert property (p_no_mail)
        else $error("mail select driven high");
    a_sel: assert property (p_sel)
        else $error("queue access without select and direction");
endmodule

// [bench/fifo_flag_sync_and_depth_chain_tb.sv]
`timescale 1ns/1ps
module fifo_flag_sync_and_depth_chain_tb;
    typedef struct {logic [1:0] mask; logic [35:0] data;} row_t;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [35:0] reg_wdata = 36'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [35:0] reg_rdata;
    logic irq;
    logic [35:0] d;
    int bad_count = 0;
    int comparisons = 0;
    row_t rows [4] = '{'{2'h0, 36'h123456789}, '{2'h1, 36'hFEDCBA987},
        '{2'h2, 36'h000000001}, '{2'h3, 36'hF0F0F0F0F}};

    always #25 ref_clk = ~ref_clk;

    fifo_port_if port_if ();
    // Both offsets are 2, so the level flags switch at a few words from either end.
    fifo_dev fifo_dev_inst (.ref_clk(ref_clk), .nrst(nrst), .port(port_if.dev),
        .low_offset(10'h002), .high_offset(10'h002));
    fifo_ctl fifo_ctl_inst (.ref_clk(ref_clk), .nrst(nrst), .port(port_if.ctl),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    fifo_flag_sync_and_depth_chain_sva checker_inst (.ref_clk(ref_clk), .nrst(nrst),
        .a_select_n(port_if.a_select_n), .a_direction(port_if.a_direction),
        .a_mail_select(port_if.a_mail_select), .a_enable(port_if.a_enable),
        .input_ready_flag(port_if.input_ready_flag),
        .high_level_flag_n(port_if.high_level_flag_n),
        .b_select_n(port_if.b_select_n), .b_direction(port_if.b_direction),
        .b_mail_select(port_if.b_mail_select), .b_enable(port_if.b_enable),
        .replay_mode_select(port_if.replay_mode_select),
        .output_ready(port_if.output_ready), .low_level_flag_n(port_if.low_level_flag_n));

    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input string n, input logic [35:0] e, input logic [35:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task wr(input logic [2:0] a, input logic [35:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [2:0] a, output logic [35:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // The controller refuses a new word while one is pending, so every transfer waits here.
    task idle;
        int n;
        n = 0;
        rd(fifo_pkg::REG_FLAGS, d);
        while (d[1:0] !== 2'h0 && n < 40) begin
            rd(fifo_pkg::REG_FLAGS, d);
            n++;
        end
        if (d[1:0] !== 2'h0) begin
            bad_count++;
            $display("unexpected pending flags: expected 0 seen %h", d[1:0]);
            test_done;
        end
    endtask

    task pop(input logic m, input logic [35:0] e);
        wr(fifo_pkg::REG_CTRL, {33'h0, 1'b1, 1'b0, m});
        idle;
        rd(fifo_pkg::REG_RDATA, d);
        chk("read word", e, d);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(fifo_pkg::REG_STATUS, d);
        chk("status", {34'h0, fifo_pkg::STATUS_RESET}, d);
        rd(fifo_pkg::REG_MASK, d);
        chk("mask", {34'h0, fifo_pkg::MASK_RESET}, d);
        rd(fifo_pkg::REG_FLAGS, d);
        chk("flags", 36'h24, d);
        rd(3'h7, d);
        chk("unmapped", 36'h0, d);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(fifo_pkg::REG_MASK, {34'h0, rows[i].mask});
            wr(fifo_pkg::REG_WDATA, rows[i].data);
            idle;
            pop(1'b0, rows[i].data);
            rd(fifo_pkg::REG_STATUS, d);
            chk("status", 36'h3, d);
            chk("irq", {35'h0, rows[i].mask != 2'h0}, {35'h0, irq});
            wr(fifo_pkg::REG_STATUS, 36'h3);
            rd(fifo_pkg::REG_STATUS, d);
            chk("status", 36'h0, d);
            chk("irq", 36'h0, {35'h0, irq});
        end
        $display("test rows done");
        for (int i = 0; i < 513; i++) begin
            wr(fifo_pkg::REG_WDATA, 36'(i));
            idle;
        end
        rd(fifo_pkg::REG_FLAGS, d);
        chk("flags", 36'h18, d);
        wr(fifo_pkg::REG_WDATA, 36'(513));
        rd(fifo_pkg::REG_FLAGS, d);
        chk("flags", 36'h19, d);
        for (int i = 0; i < 514; i++) begin
            pop(1'b0, 36'(i));
        end
        rd(fifo_pkg::REG_FLAGS, d);
        chk("flags", 36'h24, d);
        $display("test fill done");
        for (int i = 0; i < 4; i++) begin
            wr(fifo_pkg::REG_WDATA, 36'h100 + 36'(i));
            idle;
        end
        wr(fifo_pkg::REG_CTRL, 36'h1);
        pop(1'b1, 36'h100);
        pop(1'b1, 36'h101);
        wr(fifo_pkg::REG_CTRL, 36'h3);
        pop(1'b1, 36'h100);
        wr(fifo_pkg::REG_CTRL, 36'h0);
        for (int i = 1; i < 4; i++) begin
            pop(1'b0, 36'h100 + 36'(i));
        end
        $display("test replay done");
        test_done;
    end
endmodule

// [rtl/fifo_ctl.sv]
`timescale 1ns/1ps
module fifo_ctl #(
    parameter int DW = fifo_pkg::DATA_W,
    parameter bit CASCADE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic nrst,
    fifo_port_if.ctl port,
    input wire logic [fifo_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    output logic irq
);
    logic a_en_q;
    logic [DW-1:0] a_data_q;
    logic b_en_q;
    logic [DW-1:0] rword_q;
    logic mode_q;
    logic start_q;
    logic [fifo_pkg::EVT_W-1:0] sts_q;
    logic [fifo_pkg::EVT_W-1:0] sts_d;
    logic [fifo_pkg::EVT_W-1:0] mask_q;
    logic [fifo_pkg::EVT_W-1:0] set;
    logic [DW-1:0] rdata_q;
    logic irq_q;
    logic wr_done;
    logic rd_done;
    logic wr_ctrl;

    // Words move only while the far side shows ready; this is also the transfer
    // condition when this controller links two devices of a cascade.
    assign wr_done = a_en_q && port.input_ready_flag;
    assign rd_done = b_en_q && port.output_ready;
    assign wr_ctrl = reg_wr && reg_addr == fifo_pkg::REG_CTRL;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            a_en_q <= 1'b0;
            a_data_q <= '0;
        end else if (wr_done) begin
            a_en_q <= 1'b0;
        end else if (!a_en_q && reg_wr && reg_addr == fifo_pkg::REG_WDATA) begin
            a_en_q <= 1'b1;
            a_data_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            b_en_q <= 1'b0;
            rword_q <= '0;
        end else if (rd_done) begin
            b_en_q <= 1'b0;
            rword_q <= port.b_data;
        end else if (wr_ctrl && reg_wdata[fifo_pkg::CTRL_READ_REQ]) begin
            b_en_q <= 1'b1;
        end
    end

    // A cascade never replays, so the replay controls stay low there.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                mode_q <= reg_wdata[fifo_pkg::CTRL_REPLAY_MODE] && !CASCADE;
            end
            start_q <= wr_ctrl && reg_wdata[fifo_pkg::CTRL_REPLAY_START] && !CASCADE;
        end
    end

    always_comb begin
        set = '0;
        set[fifo_pkg::EVT_WRITE_DONE] = wr_done;
        set[fifo_pkg::EVT_READ_DONE] = rd_done;
        sts_d = sts_q;
        if (reg_wr && reg_addr == fifo_pkg::REG_STATUS) begin
            sts_d = sts_q & ~reg_wdata[fifo_pkg::EVT_W-1:0];
        end
        // A new event beats a clear in the same cycle.
        sts_d = sts_d | set;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sts_q <= fifo_pkg::STATUS_RESET;
            mask_q <= fifo_pkg::MASK_RESET;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            if (reg_wr && reg_addr == fifo_pkg::REG_MASK) begin
                mask_q <= reg_wdata[fifo_pkg::EVT_W-1:0];
            end
            irq_q <= |(sts_d & ((reg_wr && reg_addr == fifo_pkg::REG_MASK)
                     ? reg_wdata[fifo_pkg::EVT_W-1:0] : mask_q));
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                fifo_pkg::REG_WDATA: rdata_q <= a_data_q;
                fifo_pkg::REG_RDATA: rdata_q <= rword_q;
                fifo_pkg::REG_CTRL: rdata_q <= DW'({b_en_q, 1'b0, mode_q});
                fifo_pkg::REG_STATUS: rdata_q <= DW'(sts_q);
                fifo_pkg::REG_MASK: rdata_q <= DW'(mask_q);
                fifo_pkg::REG_FLAGS: rdata_q <= DW'({port.high_level_flag_n,
                    port.low_level_flag_n, port.output_ready, port.input_ready_flag,
                    b_en_q, a_en_q});
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    // Select and direction are held active from the first edge after reset, so every access is a queue access
    // and the mail selects never rise.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port.a_select_n <= 1'b1;
            port.a_direction <= 1'b0;
            port.b_select_n <= 1'b1;
            port.b_direction <= 1'b0;
            port.a_mail_select <= 1'b0;
            port.b_mail_select <= 1'b0;
        end else begin
            port.a_select_n <= 1'b0;
            port.a_direction <= 1'b1;
            port.b_select_n <= 1'b0;
            port.b_direction <= 1'b1;
            port.a_mail_select <= 1'b0;
            port.b_mail_select <= 1'b0;
        end
    end

    // One clock serves both ports, so in a cascade it is the faster clock by design.
    assign port.a_enable = a_en_q;
    assign port.a_data = a_data_q;
    assign port.b_enable = b_en_q;
    assign port.replay_mode_select = mode_q;
    assign port.replay_start = start_q;
    assign reg_rdata = rdata_q;
    assign irq = irq_q;
endmodule

// [rtl/fifo_dev.sv]
`timescale 1ns/1ps
module fifo_dev #(
    parameter int DEPTH = fifo_pkg::DEPTH_SMALL,
    parameter int DW = fifo_pkg::DATA_W,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic ref_clk,
    input wire logic nrst,
    fifo_port_if.dev port,
    input wire logic [AW:0] low_offset,
    input wire logic [AW:0] high_offset
);
    // Both ports run on ref_clk, so every flag moves a fixed number of edges after
    // the access that causes it and never slips by a cycle.
    localparam logic [AW:0] DEPTH_V = (AW+1)'(DEPTH);

    // A word in the output register has already left this array, so a full
    // device holds one word more than DEPTH.
    logic [DW-1:0] mem [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] wptr_d1_q;
    logic [AW:0] wptr_d2_q;
    logic [AW:0] rptr_q;
    logic [AW:0] rptr_d;
    logic [AW:0] shadow_q;
    logic [AW:0] shadow_d;
    logic [AW:0] free_q;
    logic [AW:0] free_d1_q;
    logic replay_q;
    logic replay_d;
    logic in_ready_q;
    logic high_n_q;
    logic or_q;
    logic low_n_q;
    logic [DW-1:0] out_q;
    logic wr_take;
    logic rd_take;
    logic restart;
    logic load;
    logic [AW:0] wcount;
    logic [AW:0] rcount;

    // Both ports decode a queue access the same way. A raised mail select diverts
    // the access away from the queue, so it never moves a pointer; the mailbox
    // itself is not built here.
    function automatic logic queue_access(
        input logic select_n,
        input logic direction,
        input logic mail_select,
        input logic enable
    );
        return !select_n && direction && !mail_select && enable;
    endfunction

    assign wr_take = queue_access(port.a_select_n, port.a_direction, port.a_mail_select,
                                  port.a_enable) && in_ready_q;
    assign rd_take = queue_access(port.b_select_n, port.b_direction, port.b_mail_select,
                                  port.b_enable) && or_q;
    // Replay needs no port enable at all.
    assign restart = replay_q && port.replay_start;
    // The read side sees writes only after the two pointer delay stages; the write
    // side counts a write in its own cycle, so input-ready falls with the filling write.
    assign rcount = wptr_d2_q - rptr_q;
    assign load = !restart && (!or_q || rd_take) && (rcount != '0);
    assign wcount = wptr_q + (AW+1)'(wr_take) - free_d1_q;

    // The storage has no reset: no slot is read before a write has filled it.
    always_ff @(posedge ref_clk) begin
        if (wr_take) begin
            mem[wptr_q[AW-1:0]] <= port.a_data;
        end
    end

    // Pointers carry one spare bit, so a full memory and an empty one differ.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wptr_q <= '0;
        end else if (wr_take) begin
            wptr_q <= wptr_q + (AW+1)'(1);
        end
    end

    // Two delay stages carry the write pointer to the read side, so a word reaches
    // the output register on the third read edge after its write.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wptr_d1_q <= '0;
            wptr_d2_q <= '0;
        end else begin
            wptr_d1_q <= wptr_q;
            wptr_d2_q <= wptr_d1_q;
        end
    end

    // Entering replay marks the word now in the output register, one slot behind
    // the read pointer; a restart reloads that word and reads on from the next.
    always_comb begin
        replay_d = replay_q;
        shadow_d = shadow_q;
        rptr_d = rptr_q;
        if (!replay_q && port.replay_mode_select && or_q) begin
            replay_d = 1'b1;
            shadow_d = rptr_q - (AW+1)'(1);
        end else if (replay_q && !port.replay_mode_select) begin
            replay_d = 1'b0;
        end
        if (restart) begin
            rptr_d = shadow_q + (AW+1)'(1);
        end else if (load) begin
            rptr_d = rptr_q + (AW+1)'(1);
        end
    end

    // The replay flag, the mark and the read pointer each keep a register of their own.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            replay_q <= 1'b0;
        end else begin
            replay_q <= replay_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shadow_q <= '0;
        end else begin
            shadow_q <= shadow_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rptr_q <= '0;
        end else begin
            rptr_q <= rptr_d;
        end
    end

    // The marked word is rewritten to the output register on a restart.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_q <= '0;
        end else if (restart) begin
            out_q <= mem[shadow_q[AW-1:0]];
        end else if (load) begin
            out_q <= mem[rptr_q[AW-1:0]];
        end
    end

    // A restart fills the output register at once, so output-ready follows the
    // new fill level without waiting for the pointer delay stages.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            or_q <= 1'b0;
        end else if (restart || load) begin
            or_q <= 1'b1;
        end else if (rd_take) begin
            or_q <= 1'b0;
        end
    end

    // The next read pointer is used, so a restart that lifts the count above the
    // offset raises the flag on the very next edge, inside the two-edge allowance.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            low_n_q <= 1'b0;
        end else begin
            low_n_q <= (wptr_d2_q - rptr_d) > low_offset;
        end
    end

    // During replay the write side sees the shadow pointer, which protects the
    // marked data from being overwritten.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            free_q <= '0;
            free_d1_q <= '0;
        end else begin
            free_q <= replay_d ? shadow_d : rptr_d;
            free_d1_q <= free_q;
        end
    end

    // Input-ready compares the write-side count against the full depth. Freed
    // space reaches it through two stages, which is the two-cycle settling that a
    // read or the end of replay needs before the flag rises.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_ready_q <= 1'b0;
        end else begin
            in_ready_q <= wcount != DEPTH_V;
        end
    end

    // The high-level flag uses the same count, so both flags follow a read after the same number of edges.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            high_n_q <= 1'b1;
        end else begin
            high_n_q <= wcount < (DEPTH_V - high_offset);
        end
    end

    assign port.input_ready_flag = in_ready_q;
    assign port.high_level_flag_n = high_n_q;
    assign port.output_ready = or_q;
    assign port.low_level_flag_n = low_n_q;
    assign port.b_data = out_q;
endmodule

// [rtl/fifo_pkg.sv]
// Summary of operation
// - Input-ready rises on write clock after read
// - Low-level flag clears on read clock after write
// - High-level flag clears on write clock after read
// - Queue access: select low, direction high, mail low
// - Replay driven only by replay mode and start
// - Depth is 512 or 1024 words
// - Cascade: mail selects tied low, no mailbox
// - Cascade: replay function not used
// - Cascade transfer clock is the faster clock
// - Cascade output-ready: (N-1)*4 transfer plus 3 read
// - Cascade input-ready: (N-1)*3 transfer plus 2 write
// - Replay lifts low-level flag within two edges
// - Leaving replay: two write-clock cycles before flags
// - Replay entered with mode and output-ready, left mode low
package fifo_pkg;
    localparam int DEPTH_SMALL = 512;
    localparam int DEPTH_LARGE = 1024;
    localparam int DATA_W = 36;
    localparam int OUT_READY_CYCLES = 3;
    localparam int IN_READY_CYCLES = 2;
    localparam int REG_ADDR_W = 3;
    localparam logic [2:0] REG_WDATA = 3'h0;
    localparam logic [2:0] REG_RDATA = 3'h1;
    localparam logic [2:0] REG_CTRL = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_MASK = 3'h4;
    localparam logic [2:0] REG_FLAGS = 3'h5;
    localparam int CTRL_REPLAY_MODE = 0;
    localparam int CTRL_REPLAY_START = 1;
    localparam int CTRL_READ_REQ = 2;
    localparam int EVT_W = 2;
    localparam int EVT_WRITE_DONE = 0;
    localparam int EVT_READ_DONE = 1;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
endpackage

// [rtl/fifo_port_if.sv]
`timescale 1ns/1ps
interface fifo_port_if #(
    parameter int DW = fifo_pkg::DATA_W
);
    logic a_select_n;
    logic a_direction;
    logic a_mail_select;
    logic a_enable;
    logic [DW-1:0] a_data;
    logic input_ready_flag;
    logic high_level_flag_n;
    logic b_select_n;
    logic b_direction;
    logic b_mail_select;
    logic b_enable;
    logic replay_mode_select;
    logic replay_start;
    logic [DW-1:0] b_data;
    logic output_ready;
    logic low_level_flag_n;

    modport dev (
        input a_select_n, a_direction, a_mail_select, a_enable, a_data,
        input b_select_n, b_direction, b_mail_select, b_enable,
        input replay_mode_select, replay_start,
        output input_ready_flag, high_level_flag_n, b_data, output_ready, low_level_flag_n
    );
    modport ctl (
        output a_select_n, a_direction, a_mail_select, a_enable, a_data,
        output b_select_n, b_direction, b_mail_select, b_enable,
        output replay_mode_select, replay_start,
        input input_ready_flag, high_level_flag_n, b_data, output_ready, low_level_flag_n
    );
endinterface
